/* common/fubl_defines.svh */
`ifndef FUBL_DEFINES_SVH
`define FUBL_DEFINES_SVH
// Operation
// - float operands need no address alignment
// - each float format decoder is optional
// - single: sign 15, exponent 14:7, bias 128
// - single fraction: bits 6:0 above 31:16
// - codes 1..255 give exponents -127..+127
// - zero exponent, clear sign: exact zero
// - zero exponent, set sign: reserved operand
// - reserved operand raises fault, no result
// - double adds 32 low fraction bits
// - double shares single exponent conventions
// - ext double: exponent 14:4, bias 1024
// - codes 1..2047 give exponents -1023..+1023
// - quad: exponent 14:0, bias 16384
// - codes 1..32767 give -16383..+16383
// - field sizes 0..32, base position size
// - position splits into byte offset, bit
// - signed field: bit S-1 sign extends
// - unsigned field: zero extend bits 0..S-1
// - size zero field always reads zero
// - fetch only the needed aligned longwords
// - register field position only 0..31
// - register field may continue into next
`define FUBL_SIGN_BIT    15
`define FUBL_F_EXP_HI    14
`define FUBL_F_EXP_LO    7
`define FUBL_G_EXP_LO    4
`define FUBL_F_BIAS      16'h0080
`define FUBL_G_BIAS      16'h0400
`define FUBL_H_BIAS      16'h4000
`define FUBL_EXP_W       16
`define FUBL_FRAC_W      113
`define FUBL_F_PAD       89
`define FUBL_D_PAD       57
`define FUBL_G_PAD       60
`define FUBL_FLD_MAX     6'h20
`define FUBL_REG_POS_MAX 32'h0000001f
`define FUBL_LW_STEP     32'h00000004
`endif

/* common/fubl_pkg.sv */
package fubl_pkg;

   typedef enum logic [1:0] {
      FUBL_FMT_SINGLE,
      FUBL_FMT_DOUBLE,
      FUBL_FMT_EXT_DOUBLE,
      FUBL_FMT_QUAD
   } fubl_fmt_t;

   typedef enum logic [2:0] {
      FUBL_ST_IDLE,
      FUBL_ST_RD0,
      FUBL_ST_RD1,
      FUBL_ST_EXT
   } fubl_state_t;

endpackage

/* verilog/fubl_field.sv */
`include "fubl_defines.svh"

module fubl_field (
   input  wire logic [63:0] i_window,
   input  wire logic [5:0]  i_off,
   input  wire logic [5:0]  i_size,
   input  wire logic        i_signed,
   output logic      [31:0] o_value
);

   logic [63:0] shifted;
   logic [31:0] raw;
   logic [31:0] mask;
   logic [4:0]  sign_idx;
   logic        sgn;

   always_comb begin
      shifted  = i_window >> i_off;
      raw      = shifted[31:0];
      sign_idx = i_size[4:0] - 5'h01;
      if (i_size == 6'h00) begin
         mask = 32'h00000000;
         sgn  = 1'b0;
      end else begin
         mask = 32'hffffffff >> (6'h20 - i_size);
         sgn  = i_signed & raw[sign_idx];
      end
      o_value = (raw & mask) | (sgn ? ~mask : 32'h00000000);
   end

endmodule

/* verilog/fubl_top.sv */
`include "fubl_defines.svh"

module fubl_top #(
   parameter bit P_HAS_SINGLE     = 1'b1,
   parameter bit P_HAS_DOUBLE     = 1'b1,
   parameter bit P_HAS_EXT_DOUBLE = 1'b1,
   parameter bit P_HAS_QUAD       = 1'b1
) (
   input  wire logic                    i_sys_clk,
   input  wire logic                    i_sys_rst,
   input  wire logic                    i_fp_valid,
   input  wire fubl_pkg::fubl_fmt_t     i_fp_fmt,
   input  wire logic [31:0]             i_fp_addr,
   input  wire logic [127:0]            i_fp_data,
   output logic                         o_fp_valid,
   output logic      [31:0]             o_fp_addr,
   output logic                         o_fp_sign,
   output logic      [`FUBL_EXP_W-1:0]  o_fp_exp,
   output logic      [`FUBL_FRAC_W-1:0] o_fp_frac,
   output logic                         o_fp_zero,
   output logic                         o_fp_rsvd,
   output logic                         o_fp_unsup,
   output logic                         o_fp_fault,
   input  wire logic                    i_fld_start,
   input  wire logic                    i_fld_in_reg,
   input  wire logic                    i_fld_signed,
   input  wire logic [31:0]             i_fld_base,
   input  wire logic [31:0]             i_fld_pos,
   input  wire logic [5:0]              i_fld_size,
   input  wire logic [31:0]             i_fld_reg_lo,
   input  wire logic [31:0]             i_fld_reg_hi,
   output logic                         o_mem_rd,
   output logic      [31:0]             o_mem_addr,
   input  wire logic                    i_mem_ack,
   input  wire logic [31:0]             i_mem_rdata,
   output logic                         o_fld_busy,
   output logic                         o_fld_done,
   output logic      [31:0]             o_fld_value,
   output logic                         o_fld_fault,
   output logic      [31:0]             o_fld_byte_addr,
   output logic      [2:0]              o_fld_bit_off
);

   // ---- floating operand unpack
   logic                    sign_d;
   logic                    ezero_d;
   logic                    enabled_d;
   logic [`FUBL_EXP_W-1:0]  exp_d;
   logic [`FUBL_FRAC_W-1:0] frac_d;
   logic                    zero_d;
   logic                    rsvd_d;

   always_comb begin
      sign_d    = i_fp_data[`FUBL_SIGN_BIT];
      ezero_d   = 1'b1;
      enabled_d = 1'b0;
      exp_d     = '0;
      frac_d    = '0;
      case (i_fp_fmt)
         fubl_pkg::FUBL_FMT_SINGLE: begin
            enabled_d = P_HAS_SINGLE;
            ezero_d   = (i_fp_data[14:7] == 8'h00);
            exp_d     = {8'h00, i_fp_data[14:7]} - `FUBL_F_BIAS;
            frac_d    = {1'b1, i_fp_data[6:0],
                         i_fp_data[31:16],
                         {`FUBL_F_PAD{1'b0}}};
         end
         fubl_pkg::FUBL_FMT_DOUBLE: begin
            enabled_d = P_HAS_DOUBLE;
            ezero_d   = (i_fp_data[14:7] == 8'h00);
            exp_d     = {8'h00, i_fp_data[14:7]} - `FUBL_F_BIAS;
            frac_d    = {1'b1, i_fp_data[6:0], i_fp_data[31:16],
                         i_fp_data[47:32],
                         i_fp_data[63:48],
                         {`FUBL_D_PAD{1'b0}}};
         end
         fubl_pkg::FUBL_FMT_EXT_DOUBLE: begin
            enabled_d = P_HAS_EXT_DOUBLE;
            ezero_d   = (i_fp_data[14:4] == 11'h000);
            exp_d     = {5'h00, i_fp_data[14:4]} - `FUBL_G_BIAS;
            frac_d    = {1'b1, i_fp_data[3:0],
                         i_fp_data[31:16], i_fp_data[47:32],
                         i_fp_data[63:48],
                         {`FUBL_G_PAD{1'b0}}};
         end
         fubl_pkg::FUBL_FMT_QUAD: begin
            enabled_d = P_HAS_QUAD;
            ezero_d   = (i_fp_data[14:0] == 15'h0000);
            exp_d     = {1'b0, i_fp_data[14:0]} - `FUBL_H_BIAS;
            frac_d    = {1'b1, i_fp_data[31:16],
                         i_fp_data[47:32], i_fp_data[63:48],
                         i_fp_data[79:64], i_fp_data[95:80],
                         i_fp_data[111:96], i_fp_data[127:112]};
         end
         default: begin
            enabled_d = 1'b0;
         end
      endcase
      zero_d = ezero_d & ~sign_d;
      rsvd_d = ezero_d & sign_d;
      // zero and reserved carry no magnitude downstream
      if (ezero_d || !enabled_d) begin
         exp_d  = '0;
         frac_d = '0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_fp_valid <= 1'b0;
      end else begin
         o_fp_valid <= i_fp_valid;
      end
   end

   // address only travels along; any byte address is legal
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_fp_addr <= 32'h00000000;
      end else if (i_fp_valid) begin
         o_fp_addr <= i_fp_addr;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_fp_sign <= 1'b0;
         o_fp_exp  <= '0;
         o_fp_frac <= '0;
      end else if (i_fp_valid) begin
         o_fp_sign <= sign_d;
         o_fp_exp  <= exp_d;
         o_fp_frac <= frac_d;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_fp_zero  <= 1'b0;
         o_fp_rsvd  <= 1'b0;
         o_fp_unsup <= 1'b0;
      end else if (i_fp_valid) begin
         o_fp_zero  <= zero_d & enabled_d;
         o_fp_rsvd  <= rsvd_d & enabled_d;
         o_fp_unsup <= ~enabled_d;
      end
   end

   // one-cycle pulse; an omitted format faults the same way
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_fp_fault <= 1'b0;
      end else begin
         o_fp_fault <= i_fp_valid & (rsvd_d | ~enabled_d);
      end
   end

   // ---- variable-length bit field
   fubl_pkg::fubl_state_t state_q;
   fubl_pkg::fubl_state_t state_d;
   logic [31:0] byte_off;
   logic [31:0] start_addr;
   logic [31:0] lw_addr;
   logic [5:0]  mem_off;
   logic [6:0]  end_bit;
   logic        two_lw;
   logic        size_bad;
   logic        pos_bad;
   logic [63:0] window_q;
   logic [5:0]  off_q;
   logic [5:0]  size_q;
   logic        signed_q;
   logic        two_q;
   logic        fault_q;
   logic [31:0] ext_value;

   always_comb begin
      byte_off   = {{3{i_fld_pos[31]}}, i_fld_pos[31:3]};
      start_addr = i_fld_base + byte_off;
      lw_addr    = {start_addr[31:2], 2'b00};
      mem_off    = {1'b0, start_addr[1:0], i_fld_pos[2:0]};
      end_bit    = {1'b0, mem_off} + {1'b0, i_fld_size};
      two_lw     = (end_bit > 7'h20);
      size_bad   = (i_fld_size > `FUBL_FLD_MAX);
      pos_bad    = (i_fld_pos > `FUBL_REG_POS_MAX);
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         fubl_pkg::FUBL_ST_IDLE: begin
            if (i_fld_start) begin
               if (size_bad || (i_fld_in_reg && pos_bad)) begin
                  state_d = fubl_pkg::FUBL_ST_EXT;
               end else if (i_fld_in_reg) begin
                  state_d = fubl_pkg::FUBL_ST_EXT;
               end else if (i_fld_size == 6'h00) begin
                  // no memory reference for an empty field
                  state_d = fubl_pkg::FUBL_ST_EXT;
               end else begin
                  state_d = fubl_pkg::FUBL_ST_RD0;
               end
            end
         end
         fubl_pkg::FUBL_ST_RD0: begin
            if (i_mem_ack) begin
               state_d = two_q ? fubl_pkg::FUBL_ST_RD1
                               : fubl_pkg::FUBL_ST_EXT;
            end
         end
         fubl_pkg::FUBL_ST_RD1: begin
            if (i_mem_ack) begin
               state_d = fubl_pkg::FUBL_ST_EXT;
            end
         end
         fubl_pkg::FUBL_ST_EXT: begin
            state_d = fubl_pkg::FUBL_ST_IDLE;
         end
         default: begin
            state_d = fubl_pkg::FUBL_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         state_q <= fubl_pkg::FUBL_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // request captured once; inputs may change while busy
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         off_q    <= 6'h00;
         size_q   <= 6'h00;
         signed_q <= 1'b0;
         two_q    <= 1'b0;
         fault_q  <= 1'b0;
      end else if (state_q == fubl_pkg::FUBL_ST_IDLE && i_fld_start) begin
         off_q    <= i_fld_in_reg ? {1'b0, i_fld_pos[4:0]} : mem_off;
         size_q   <= i_fld_size;
         signed_q <= i_fld_signed;
         two_q    <= two_lw;
         fault_q  <= size_bad | (i_fld_in_reg & pos_bad);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         window_q <= 64'h0000000000000000;
      end else if (state_q == fubl_pkg::FUBL_ST_IDLE && i_fld_start) begin
         if (i_fld_in_reg) begin
            window_q <= {i_fld_reg_hi, i_fld_reg_lo};
         end else begin
            window_q <= 64'h0000000000000000;
         end
      end else if (i_mem_ack && state_q == fubl_pkg::FUBL_ST_RD0) begin
         window_q[31:0] <= i_mem_rdata;
      end else if (i_mem_ack && state_q == fubl_pkg::FUBL_ST_RD1) begin
         window_q[63:32] <= i_mem_rdata;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_mem_rd <= 1'b0;
      end else begin
         o_mem_rd <= (state_d == fubl_pkg::FUBL_ST_RD0) ||
                     (state_d == fubl_pkg::FUBL_ST_RD1);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_mem_addr <= 32'h00000000;
      end else if (state_q == fubl_pkg::FUBL_ST_IDLE && i_fld_start) begin
         o_mem_addr <= lw_addr;
      end else if (i_mem_ack && state_q == fubl_pkg::FUBL_ST_RD0) begin
         o_mem_addr <= o_mem_addr + `FUBL_LW_STEP;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_fld_byte_addr <= 32'h00000000;
         o_fld_bit_off   <= 3'h0;
      end else if (state_q == fubl_pkg::FUBL_ST_IDLE && i_fld_start) begin
         o_fld_byte_addr <= start_addr;
         o_fld_bit_off   <= i_fld_pos[2:0];
      end
   end

   fubl_field u_field (
      .i_window (window_q),
      .i_off    (off_q),
      .i_size   (size_q),
      .i_signed (signed_q),
      .o_value  (ext_value)
   );

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_fld_busy <= 1'b0;
      end else begin
         o_fld_busy <= (state_d != fubl_pkg::FUBL_ST_IDLE);
      end
   end

   // faulted field yields zero rather than a partial value
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_fld_done  <= 1'b0;
         o_fld_fault <= 1'b0;
         o_fld_value <= 32'h00000000;
      end else if (state_q == fubl_pkg::FUBL_ST_EXT) begin
         o_fld_done  <= 1'b1;
         o_fld_fault <= fault_q;
         o_fld_value <= fault_q ? 32'h00000000 : ext_value;
      end else begin
         o_fld_done  <= 1'b0;
         o_fld_fault <= 1'b0;
      end
   end

endmodule

/* tb/fubl_top_chk.sv */
module fubl_top_chk #(
   parameter bit P_HAS_SINGLE = 1'b1,
   parameter bit P_HAS_QUAD   = 1'b1
) (
   input wire logic                i_sys_clk,
   input wire logic                i_sys_rst,
   input wire logic                i_fp_valid,
   input wire fubl_pkg::fubl_fmt_t i_fp_fmt,
   input wire logic [127:0]        i_fp_data,
   input wire logic                o_fp_valid,
   input wire logic                o_fp_sign,
   input wire logic [15:0]         o_fp_exp,
   input wire logic [112:0]        o_fp_frac,
   input wire logic                o_fp_zero,
   input wire logic                o_fp_rsvd,
   input wire logic                o_fp_unsup,
   input wire logic                o_fp_fault,
   input wire logic                i_fld_start,
   input wire logic                i_fld_in_reg,
   input wire logic [5:0]          i_fld_size,
   input wire logic                o_mem_rd,
   input wire logic [31:0]         o_mem_addr,
   input wire logic                i_mem_ack,
   input wire logic                o_fld_busy,
   input wire logic                o_fld_done,
   input wire logic [31:0]         o_fld_value,
   input wire logic                o_fld_fault
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   logic take;
   // start counts only when neither busy nor done; the design also takes one in the done cycle
   assign take = i_fld_start && !o_fld_busy && !o_fld_done;

   a_unpack_lat: assert property (i_fp_valid |=> o_fp_valid)
      else $error("unpack result late");
   a_no_stray: assert property (!i_fp_valid |=> !o_fp_valid && !o_fp_fault)
      else $error("unpack result without operand");
   a_fault_cause: assert property (o_fp_fault |-> o_fp_rsvd || o_fp_unsup)
      else $error("fault without cause");
   a_rsvd_fault: assert property (o_fp_valid && o_fp_rsvd |-> o_fp_fault)
      else $error("reserved operand not faulted");
   a_zero_clean: assert property (o_fp_zero |-> !o_fp_sign &&
      o_fp_exp == 16'h0000 && o_fp_frac == '0) else $error("zero not clean");
   a_rsvd_class: assert property (o_fp_rsvd |-> o_fp_sign &&
      !o_fp_zero && o_fp_exp == 16'h0000) else $error("reserved misclassed");
   a_hidden_one: assert property (o_fp_valid && !o_fp_zero &&
      !o_fp_rsvd && !o_fp_unsup |-> o_fp_frac[112]) else $error("no hidden bit");
   a_single_exp: assert property (P_HAS_SINGLE && i_fp_valid &&
      i_fp_fmt == fubl_pkg::FUBL_FMT_SINGLE && i_fp_data[14:7] != 8'h00 |=>
      o_fp_exp == {8'h00, $past(i_fp_data[14:7])} - 16'h0080)
      else $error("single exponent wrong");
   a_quad_exp: assert property (P_HAS_QUAD && i_fp_valid &&
      i_fp_fmt == fubl_pkg::FUBL_FMT_QUAD && i_fp_data[14:0] != 15'h0000 |=>
      o_fp_exp == {1'b0, $past(i_fp_data[14:0])} - 16'h4000)
      else $error("quad exponent wrong");
   a_reg_timing: assert property (take && i_fld_in_reg |=>
      o_fld_busy ##1 (o_fld_done && !o_fld_busy)) else $error("reg field late");
   a_rd_aligned: assert property (o_mem_rd |-> o_mem_addr[1:0] == 2'b00)
      else $error("unaligned fetch");
   a_rd_held: assert property (o_mem_rd && !i_mem_ack |=>
      o_mem_rd && $stable(o_mem_addr)) else $error("read dropped early");
   a_size0_quiet: assert property (take && !i_fld_in_reg &&
      i_fld_size == 6'h00 |=> !o_mem_rd [*2]) else $error("size zero fetched");
   a_fault_zero: assert property (o_fld_fault |-> o_fld_done &&
      o_fld_value == 32'h00000000) else $error("faulted field not zero");
endmodule

bind fubl_top fubl_top_chk #(
   .P_HAS_SINGLE(P_HAS_SINGLE),
   .P_HAS_QUAD  (P_HAS_QUAD)
) u_chk (
   .i_sys_clk, .i_sys_rst, .i_fp_valid, .i_fp_fmt, .i_fp_data, .o_fp_valid,
   .o_fp_sign, .o_fp_exp, .o_fp_frac, .o_fp_zero, .o_fp_rsvd, .o_fp_unsup,
   .o_fp_fault, .i_fld_start, .i_fld_in_reg, .i_fld_size, .o_mem_rd,
   .o_mem_addr, .i_mem_ack, .o_fld_busy, .o_fld_done, .o_fld_value,
   .o_fld_fault
);

/* tb/fubl_mem_model.sv */
module fubl_mem_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rd,
   input  wire logic [31:0] i_addr,
   input  wire logic [3:0]  i_lat,
   output logic             o_ack,
   output logic      [31:0] o_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_q;
   initial begin
      o_ack = 1'b0;
      o_rdata = 32'h00000000;
      cnt_q = 4'h0;
   end
   // contents follow the address so a misrouted fetch shows
   always @(posedge i_sys_clk) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      cnt_q <= 4'h0;
      if (i_rd && !o_ack) begin
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q >= i_lat) begin
            o_ack <= 1'b1;
            o_rdata <= {~i_addr[15:0], i_addr[15:0]} ^ 32'h3c5a96e1;
            cnt_q <= 4'h0;
         end
      end
   end
endmodule

/* tb/fubl_top_test.sv */
module fubl_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic         i_sys_clk, i_sys_rst, i_fp_valid, i_fld_start, i_fld_in_reg;
   logic         i_fld_signed, i_mem_ack, o_fp_valid, o_fp_sign, o_fp_zero;
   logic         o_fp_rsvd, o_fp_unsup, o_fp_fault, o_mem_rd, o_fld_busy;
   logic         o_fld_done, o_fld_fault;
   logic [2:0]   o_fld_bit_off;
   logic [3:0]   lat;
   logic [5:0]   i_fld_size;
   logic [15:0]  o_fp_exp;
   logic [31:0]  i_fp_addr, i_fld_base, i_fld_pos, i_fld_reg_lo, i_fld_reg_hi;
   logic [31:0]  i_mem_rdata, o_fp_addr, o_mem_addr, o_fld_value;
   logic [31:0]  o_fld_byte_addr, ad0, ad1;
   logic [112:0] o_fp_frac;
   logic [127:0] i_fp_data;
   fubl_pkg::fubl_fmt_t i_fp_fmt;
   int           n_fail = 0, n_tests = 0, nrd = 0;

   fubl_top dut (
      .i_sys_clk, .i_sys_rst, .i_fp_valid, .i_fp_fmt, .i_fp_addr, .i_fp_data,
      .o_fp_valid, .o_fp_addr, .o_fp_sign, .o_fp_exp, .o_fp_frac, .o_fp_zero,
      .o_fp_rsvd, .o_fp_unsup, .o_fp_fault, .i_fld_start, .i_fld_in_reg,
      .i_fld_signed, .i_fld_base, .i_fld_pos, .i_fld_size, .i_fld_reg_lo,
      .i_fld_reg_hi, .o_mem_rd, .o_mem_addr, .i_mem_ack, .i_mem_rdata,
      .o_fld_busy, .o_fld_done, .o_fld_value, .o_fld_fault, .o_fld_byte_addr,
      .o_fld_bit_off
   );
   fubl_mem_model mem (.i_sys_clk, .i_rd(o_mem_rd), .i_addr(o_mem_addr),
      .i_lat(lat), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

   initial begin
      i_sys_clk = 1'b0;
      forever #50 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) begin
      if (o_mem_rd && i_mem_ack) begin
         if (nrd == 0) ad0 = o_mem_addr;
         else ad1 = o_mem_addr;
         nrd++;
      end
   end

   function automatic logic [31:0] lw(input logic [31:0] a);
      return {~a[15:0], a[15:0]} ^ 32'h3c5a96e1;
   endfunction
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic results;
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // valid stays up between calls, so operands go back to back
   task automatic fp_case(input fubl_pkg::fubl_fmt_t f, input logic [127:0] d);
      logic [112:0] fr;
      logic [15:0]  ex;
      logic         zf;
      fr = '0;
      case (f)
         fubl_pkg::FUBL_FMT_SINGLE: begin
            ex = {8'h00, d[14:7]} - 16'h0080;
            zf = d[14:7] == 8'h00;
            fr[112:89] = {1'b1, d[6:0], d[31:16]};
         end
         fubl_pkg::FUBL_FMT_DOUBLE: begin
            ex = {8'h00, d[14:7]} - 16'h0080;
            zf = d[14:7] == 8'h00;
            fr[112:57] = {1'b1, d[6:0], d[31:16], d[47:32], d[63:48]};
         end
         fubl_pkg::FUBL_FMT_EXT_DOUBLE: begin
            ex = {5'h00, d[14:4]} - 16'h0400;
            zf = d[14:4] == 11'h000;
            fr[112:60] = {1'b1, d[3:0], d[31:16], d[47:32], d[63:48]};
         end
         default: begin
            ex = {1'b0, d[14:0]} - 16'h4000;
            zf = d[14:0] == 15'h0000;
            fr = {1'b1, d[31:16], d[47:32], d[63:48], d[79:64], d[95:80],
                  d[111:96], d[127:112]};
         end
      endcase
      if (zf) begin
         ex = 16'h0000;
         fr = '0;
      end
      i_fp_valid = 1'b1;
      i_fp_fmt = f;
      i_fp_data = d;
      i_fp_addr = d[31:0] | 32'h00000001;
      @(negedge i_sys_clk);
      chk(o_fp_valid === 1'b1 && o_fp_addr === (d[31:0] | 32'h1), "fp valid");
      chk(o_fp_sign === d[15] && o_fp_exp === ex && o_fp_frac === fr, "fp data");
      chk(o_fp_zero === (zf & ~d[15]) && o_fp_rsvd === (zf & d[15]) &&
          o_fp_fault === (zf & d[15]) && o_fp_unsup === 1'b0, "fp class");
   endtask

   task automatic t_unpack;
      fp_case(fubl_pkg::FUBL_FMT_SINGLE, 128'ha5c300d5);
      fp_case(fubl_pkg::FUBL_FMT_SINGLE, 128'h1234ffaa);
      fp_case(fubl_pkg::FUBL_FMT_SINGLE, 128'hdead007f);
      fp_case(fubl_pkg::FUBL_FMT_DOUBLE, 128'h89abcdef012340bc);
      fp_case(fubl_pkg::FUBL_FMT_DOUBLE, 128'hffffffffffff807f);
      fp_case(fubl_pkg::FUBL_FMT_EXT_DOUBLE, 128'hfedcba98765447f5);
      fp_case(fubl_pkg::FUBL_FMT_EXT_DOUBLE, 128'h123456789abc000f);
      fp_case(fubl_pkg::FUBL_FMT_QUAD, {96'h0123456789abcdef13572468, 32'h9bdf7fff});
      fp_case(fubl_pkg::FUBL_FMT_QUAD, {96'h1, 32'hffff8000});
      i_fp_valid = 1'b0;
      $display("unpack test end");
   endtask

   task automatic fld(input logic rg, sg, pk, input logic [31:0] b, p,
                      input logic [5:0] s, input logic [31:0] lo, hi);
      logic [31:0] st, a, v;
      logic [63:0] w, m;
      logic [6:0]  off;
      logic        bad;
      int          nx;
      st = b + {{3{p[31]}}, p[31:3]};
      a = {st[31:2], 2'b00};
      off = rg ? {2'b00, p[4:0]} : {2'b00, st[1:0], 3'b000} + {4'h0, p[2:0]};
      w = rg ? {hi, lo} : {lw(a + 32'h4), lw(a)};
      w = w >> off;
      m = (64'h1 << s) - 64'h1;
      v = w[31:0] & m[31:0];
      if (sg && s != 6'h00 && w[s-1]) v = v | ~m[31:0];
      bad = s > 6'h20 || (rg && p > 32'h1f);
      if (bad) v = '0;
      nx = (bad || rg || s == 6'h00) ? 0 : ((off + s > 32) ? 2 : 1);
      @(negedge i_sys_clk);
      {i_fld_in_reg, i_fld_signed, i_fld_base, i_fld_pos} = {rg, sg, b, p};
      i_fld_size = s;
      i_fld_reg_lo = lo;
      i_fld_reg_hi = hi;
      i_fld_start = 1'b1;
      nrd = 0;
      @(negedge i_sys_clk);
      // a second start while busy must change nothing
      i_fld_start = pk;
      if (pk) i_fld_size = 6'h21;
      for (int k = 0; k < 60 && o_fld_done !== 1'b1; k++) begin
         @(negedge i_sys_clk);
         i_fld_start = 1'b0;
      end
      chk(o_fld_done === 1'b1 && o_fld_busy === 1'b0, "fld done");
      chk(o_fld_value === v && o_fld_fault === bad, "fld value");
      chk(nrd == nx && (nx == 0 || ad0 === a) && (nx < 2 || ad1 === a + 32'h4), "fld reads");
      if (!rg) chk(o_fld_byte_addr === st && o_fld_bit_off === p[2:0], "fld start");
   endtask

   task automatic t_reg;
      fld(1, 0, 0, 0, 28, 8, 32'h90000000, 32'h0000000c);
      fld(1, 1, 0, 0, 4, 5, 32'h00000150, 32'h0);
      fld(1, 0, 0, 0, 32, 4, 32'hffffffff, 32'h0);
      fld(1, 1, 0, 0, 0, 32, 32'h80000001, 32'h0);
      $display("register field test end");
   endtask

   task automatic t_mem;
      lat = 4'h0;
      fld(0, 0, 0, 32'h1001, 5, 12, 0, 0);
      lat = 4'h3;
      fld(0, 1, 0, 32'h2000, 32'hfffffff3, 20, 0, 0);
      fld(0, 0, 0, 32'h3003, 7, 32, 0, 0);
      fld(0, 0, 0, 32'h3000, 0, 32, 0, 0);
      fld(0, 1, 0, 32'h4002, 3, 0, 0, 0);
      fld(0, 0, 0, 32'h4000, 0, 33, 0, 0);
      lat = 4'h5;
      fld(0, 0, 1, 32'h5001, 9, 30, 0, 0);
      $display("memory field test end");
   endtask

   initial begin
      {i_fp_valid, i_fld_start, i_fld_in_reg, i_fld_signed, lat} = '0;
      {i_fp_addr, i_fp_data, i_fld_size} = '0;
      {i_fld_base, i_fld_pos, i_fld_reg_lo, i_fld_reg_hi} = '0;
      i_fp_fmt = fubl_pkg::FUBL_FMT_SINGLE;
      i_sys_rst = 1'b1;
      repeat (3) @(negedge i_sys_clk);
      i_sys_rst = 1'b0;
      chk(o_fp_valid === 1'b0 && o_fld_busy === 1'b0 && o_mem_rd === 1'b0, "reset");
      t_unpack();
      t_reg();
      t_mem();
      results();
   end
   initial begin
      #(3000 * 100);
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      results();
   end
endmodule
